// >>> src/osc_startup_defs.svh
// Offsets, field positions, reset values and timing counts of the start-up clock block
// Included by the design modules and the testbench
`ifndef OSC_STARTUP_DEFS_SVH
`define OSC_STARTUP_DEFS_SVH
`define OFS_CONFIG          12'h000
`define OFS_STATUS          12'h004
`define OFS_CONTROL         12'h008
`define BIT_SWITCHOVER      7
`define BIT_SLOW_RC_POWER   6
`define BIT_SECONDARY_PIN   5
`define MASK_CONFIG         8'he7
`define RST_CONFIG          8'he1
`define RST_CONTROL         32'h00000000
`define BIT_READY_IN        0
`define BIT_SWITCH_DONE     1
`define FIELD_SELECT_LSB    0
`define FIELD_SELECT_MSB    2
`define OSC_WAIT_NS         100000
`define CLK_PERIOD_NS       50
`define OSC_WAIT_CYCLES     ((`OSC_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> src/osc_startup_pkg.sv
// Types shared by the start-up clock block
// Assumes osc_startup_defs.svh is on the include path
package osc_startup_pkg;
   typedef enum logic [2:0] {
      sel_fast_rc         = 3'h0,
      sel_fast_rc_pll     = 3'h1,
      sel_primary         = 3'h2,
      sel_primary_pll     = 3'h3,
      sel_secondary       = 3'h4,
      sel_low_power_rc    = 3'h5,
      sel_low_power_fast  = 3'h6,
      sel_fast_rc_divided = 3'h7
   } initial_osc_select_t;

   typedef enum logic [2:0] {
      src_fast_rc,
      src_primary,
      src_secondary,
      src_low_power_rc,
      src_low_power_fast
   } osc_source_t;

   typedef struct packed {
      logic                startup_switchover_enable;
      logic                slow_rc_power_select;
      logic                secondary_pin_function_select;
      initial_osc_select_t initial_osc_select;
   } osc_config_t;

   typedef struct packed {
      osc_source_t source;
      logic        use_pll;
      logic        use_divider;
   } osc_route_t;
endpackage : osc_startup_pkg

// >>> src/config_latch.sv
// Holder of the sampled configuration byte
// Assumes the byte input is stable while aresetn is low
`timescale 1ns/100ps
`include "osc_startup_defs.svh"
module config_latch
   import osc_startup_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Configuration byte
   input  wire logic [7:0] config_byte,
   output      logic [7:0] held_byte
);
   logic [7:0] next_held_byte;
   logic       sampled;
   logic       next_sampled;

   always_comb begin
      next_held_byte = held_byte;
      next_sampled   = 1'b1;
      if (!sampled) begin
         next_held_byte = config_byte & `MASK_CONFIG;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held_byte <= `RST_CONFIG;
         sampled   <= 1'b0;
      end else begin
         held_byte <= next_held_byte;
         sampled   <= next_sampled;
      end
   end
endmodule : config_latch

// >>> src/oscillator_startup_select.sv
// Start-up oscillator selection from the configuration byte, AXI4-Lite status view
// Assumes the oscillator sources, PLL and divider live outside and report readiness
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "osc_startup_defs.svh"
module oscillator_startup_select
   import osc_startup_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Configuration byte and oscillator readiness
   input  wire logic [7:0]  config_byte,
   input  wire logic        external_ready,
   // Clock routing outputs
   output      osc_route_t  active_route,
   output      logic        slow_rc_high_power,
   output      logic        secondary_crystal_enable,
   output      logic        secondary_digital_clock_input_enable,
   output      logic        switchover_active,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   // AXI4-Lite read data
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam int unsigned WAIT_CYCLES = `OSC_WAIT_CYCLES;

   typedef enum logic [1:0] {st_internal, st_external, st_direct} start_state_t;

   logic [7:0]   held_byte;
   osc_config_t  cfg;
   osc_route_t   target_route;
   osc_route_t   next_active_route;
   start_state_t state;
   start_state_t next_state;
   logic [12:0]  wait_count;
   logic [12:0]  next_wait_count;
   logic [31:0]  control;
   logic [31:0]  next_control;
   logic         aw_held, next_aw_held, w_held, next_w_held;
   logic [11:0]  aw_addr, next_aw_addr;
   logic [31:0]  w_data, next_w_data;
   logic [3:0]   w_strb, next_w_strb;
   logic         next_bvalid, next_rvalid;
   logic [1:0]   next_bresp, next_rresp;
   logic [31:0]  next_rdata;

   config_latch u_config_latch (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .config_byte (config_byte),
      .held_byte   (held_byte)
   );

   assign cfg = osc_config_t'({held_byte[7:5], held_byte[`FIELD_SELECT_MSB:`FIELD_SELECT_LSB]});

   // Maps the three-bit select code onto a source and its PLL and divider use
   function automatic osc_route_t decode_select(input initial_osc_select_t code);
      osc_route_t r;
      r = '{source: src_fast_rc, use_pll: 1'b0, use_divider: 1'b0};
      unique case (code)
         sel_fast_rc:         r = '{src_fast_rc, 1'b0, 1'b0};
         sel_fast_rc_pll:     r = '{src_fast_rc, 1'b1, 1'b1};
         sel_fast_rc_divided: r = '{src_fast_rc, 1'b0, 1'b1};
         sel_primary:         r = '{src_primary, 1'b0, 1'b0};
         sel_primary_pll:     r = '{src_primary, 1'b1, 1'b0};
         sel_low_power_fast:  r = '{src_low_power_fast, 1'b0, 1'b1};
         sel_low_power_rc:    r = '{src_low_power_rc, 1'b0, 1'b0};
         sel_secondary:       r = '{src_secondary, 1'b0, 1'b0};
      endcase
      return r;
   endfunction : decode_select

   // True when the selected source is external to the chip and needs settling
   function automatic logic is_external(input osc_route_t r);
      return (r.source == src_primary) || (r.source == src_secondary);
   endfunction : is_external

   assign target_route                         = decode_select(cfg.initial_osc_select);
   assign slow_rc_high_power                   = cfg.slow_rc_power_select;
   assign secondary_crystal_enable             = cfg.secondary_pin_function_select;
   assign secondary_digital_clock_input_enable = ~cfg.secondary_pin_function_select;
   assign switchover_active                    = (state == st_internal);

   // Start-up sequence
   always_comb begin
      next_state        = state;
      next_wait_count   = wait_count;
      next_active_route = active_route;
      unique case (state)
         st_direct: begin
            next_active_route = target_route;
            if (cfg.startup_switchover_enable && is_external(target_route)
                && wait_count == 13'h0000) begin
               next_state        = st_internal;
               next_active_route = '{src_fast_rc, 1'b0, 1'b0};
               next_wait_count   = 13'h0001;
            end
         end
         st_internal: begin
            next_active_route = '{src_fast_rc, 1'b0, 1'b0};
            if (wait_count < WAIT_CYCLES[12:0]) begin
               next_wait_count = wait_count + 13'h0001;
            end
            if (external_ready && (wait_count >= WAIT_CYCLES[12:0] || control[0])) begin
               next_state        = st_external;
               next_active_route = target_route;
            end
         end
         st_external: begin
            next_active_route = target_route;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state        <= st_direct;
         wait_count   <= 13'h0000;
         active_route <= '{src_fast_rc, 1'b0, 1'b0};
      end else begin
         state        <= next_state;
         wait_count   <= next_wait_count;
         active_route <= next_active_route;
      end
   end

   // AXI4-Lite slave
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_control = control;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (aw_held && w_held) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = 2'h0;
         if (aw_addr[11:2] == 10'(`OFS_CONTROL >> 2)) begin
            if (w_strb[0]) begin
               next_control[0] = w_data[0];
            end
         end else if (aw_addr[11:2] == 10'(`OFS_CONFIG >> 2)
                      || aw_addr[11:2] == 10'(`OFS_STATUS >> 2)) begin
            next_bresp = 2'h2;
         end else begin
            next_bresp = 2'h3;
         end
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = 2'h0;
         unique case (s_axi_araddr[11:2])
            10'(`OFS_CONFIG >> 2):  next_rdata = {24'h000000, held_byte};
            10'(`OFS_STATUS >> 2):  next_rdata = {27'h0000000, state == st_external,
                                                  switchover_active, external_ready,
                                                  target_route.use_pll, 1'b0};
            10'(`OFS_CONTROL >> 2): next_rdata = control;
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = 2'h3;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         control      <= `RST_CONTROL;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         control      <= next_control;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp  <= next_rresp;
         s_axi_rdata  <= next_rdata;
      end
   end
endmodule : oscillator_startup_select

// >>> dv/osc_startup_checker.sv
// Checker of the start-up clock selections, bound to oscillator_startup_select
// Assumes the configuration byte is steady while aresetn is low
`timescale 1ns/100ps
module osc_startup_checker
   import osc_startup_pkg::*;
(
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Observed ports
   input wire logic [7:0] config_byte,
   input wire logic       external_ready,
   input wire osc_route_t active_route,
   input wire logic       slow_rc_high_power,
   input wire logic       secondary_crystal_enable,
   input wire logic       secondary_digital_clock_input_enable,
   input wire logic       switchover_active
);
   logic [1:0] cnt;
   logic [7:0] cfg;
   logic       settled;
   // Own copy of the byte taken at the first edge after release
   always_ff @(posedge aclk) begin
      if (!aresetn) cnt <= 2'h0;
      else if (cnt != 2'h3) cnt <= cnt + 2'h1;
      if (aresetn && cnt == 2'h0) cfg <= config_byte & 8'he7;
   end
   assign settled = (cnt == 2'h3);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   pin_split_a: assert property (
      secondary_crystal_enable ^ secondary_digital_clock_input_enable)
      else $error("crystal and digital input enables agree");
   crystal_bit_a: assert property (
      settled |-> secondary_crystal_enable == cfg[5])
      else $error("crystal enable differs from held byte");
   slow_power_a: assert property (
      settled |-> slow_rc_high_power == cfg[6])
      else $error("slow rc power differs from held byte");
   held_config_a: assert property (
      settled |-> $stable(slow_rc_high_power) && $stable(secondary_crystal_enable))
      else $error("selection changed without reset");
   no_switchover_a: assert property (
      settled && !cfg[7] |-> !switchover_active)
      else $error("two-speed start-up while disabled");
   internal_run_a: assert property (
      switchover_active |-> active_route.source == src_fast_rc)
      else $error("two-speed start-up not on fast rc");
   startup_internal_a: assert property (
      settled && cfg[7] && cfg[2:0] inside {3'h2, 3'h3, 3'h4} && !external_ready
      |-> switchover_active)
      else $error("left internal oscillator before ready");
   pll_route_a: assert property (
      settled && !switchover_active && !$past(switchover_active)
      |-> active_route.use_pll == (cfg[2:0] == 3'h1 || cfg[2:0] == 3'h3))
      else $error("pll use differs from code");
   divider_route_a: assert property (
      settled && !switchover_active && !$past(switchover_active)
      |-> active_route.use_divider == (cfg[2:0] inside {3'h1, 3'h6, 3'h7}))
      else $error("divider use differs from code");
endmodule : osc_startup_checker

bind oscillator_startup_select osc_startup_checker chk (.aclk, .aresetn, .config_byte,
   .external_ready, .active_route, .slow_rc_high_power, .secondary_crystal_enable,
   .secondary_digital_clock_input_enable, .switchover_active);

// >>> dv/tb.sv
// Self-checking bench of the start-up clock selection block
// Assumes the checker binds itself to the design
`timescale 1ns/100ps
`include "osc_startup_defs.svh"
module tb
   import osc_startup_pkg::*;
;
   logic        aclk, aresetn, external_ready;
   logic [7:0]  config_byte, b;
   osc_route_t  active_route;
   logic        slow_rc_high_power, secondary_crystal_enable;
   logic        secondary_digital_clock_input_enable, switchover_active;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          error_cnt, samples_checked, cycles;
   oscillator_startup_select dut (.aclk, .aresetn, .config_byte, .external_ready,
      .active_route, .slow_rc_high_power, .secondary_crystal_enable,
      .secondary_digital_clock_input_enable, .switchover_active, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   function automatic osc_route_t exp_route(input logic [2:0] c);
      osc_route_t r;
      case (c)
         3'h2, 3'h3: r.source = src_primary;
         3'h4: r.source = src_secondary;
         3'h5: r.source = src_low_power_rc;
         3'h6: r.source = src_low_power_fast;
         default: r.source = src_fast_rc;
      endcase
      r.use_pll = (c == 3'h1) || (c == 3'h3);
      r.use_divider = (c == 3'h1) || (c >= 3'h6);
      return r;
   endfunction : exp_route
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1;
      w = 1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read
   task automatic run_cfg(input logic [7:0] v);
      logic [31:0] d;
      logic [1:0]  r;
      logic        ext;
      logic        n_ok;
      osc_route_t  e;
      int          n;
      ext = v[7] && (v[2:0] inside {3'h2, 3'h3, 3'h4});
      e = exp_route(v[2:0]);
      external_ready <= 1'b0;
      config_byte <= v;
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      config_byte <= ~v;
      repeat (3) @(posedge aclk);
      chk(32'(slow_rc_high_power), 32'(v[6]));
      chk(32'(secondary_crystal_enable), 32'(v[5]));
      chk(32'(secondary_digital_clock_input_enable), 32'(!v[5]));
      chk(32'(switchover_active), 32'(ext));
      if (ext) chk(32'(active_route.source), 32'(src_fast_rc));
      else chk(32'(active_route), 32'(e));
      axi_read(`OFS_CONFIG, d, r);
      chk(d, {24'h0, v & 8'he7});
      axi_read(`OFS_STATUS, d, r);
      chk(d, {27'h0, 1'b0, ext, 1'b0, e.use_pll, 1'b0});
      axi_write(`OFS_CONFIG, 32'(~v), r);
      chk(32'(r), 32'h2);
      axi_write(12'h010, 32'(v), r);
      chk(32'(r), 32'h3);
      axi_read(12'h010, d, r);
      chk({d[29:0], r}, 32'h3);
      axi_write(`OFS_CONTROL, 32'(v[4]), r);
      chk(32'(r), 32'h0);
      axi_read(`OFS_CONTROL, d, r);
      chk(d, 32'(v[4]));
      if (ext) begin
         repeat (5) @(posedge aclk);
         chk(32'(switchover_active), 32'h1);
         external_ready <= 1'b1;
         n = 0;
         while (switchover_active !== 1'b0 && n < 2200) begin
            @(posedge aclk);
            n++;
         end
         n_ok = v[4] ? (n <= 2) : (n >= `OSC_WAIT_CYCLES - 100 && n <= `OSC_WAIT_CYCLES);
         chk(32'(n_ok), 32'h1);
         repeat (2) @(posedge aclk);
         chk(32'(active_route), 32'(e));
         axi_read(`OFS_STATUS, d, r);
         chk(d, {27'h0, 1'b1, 1'b0, 1'b1, e.use_pll, 1'b0});
      end
   endtask : run_cfg
   task tally_and_finish;
      if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         $display("unexpected %0t run too long", $time);
         tally_and_finish();
      end
   end
   initial begin
      aresetn = 1'b0;
      config_byte = 8'h00;
      external_ready = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      error_cnt = 0;
      samples_checked = 0;
      cycles = 0;
      void'($urandom(78));
      for (int i = 0; i < 24; i++) begin
         b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         b[2:0] = i[2:0];
         if (i < 16) b[7] = i[3];
         run_cfg(b);
      end
      tally_and_finish();
   end
endmodule : tb
